// ---- verilog/emlog_map.svh ----
// Constants for the error memory log: indices, sub-indices, codes and timing
// Operation
// (RL1) Keep twenty newest error reports separately
// (RL2) Oldest at index 900, newest upward
// (RL3) Sub 1 number, sub 2 class, read-only
// (RL4) Sub 3 milliseconds since amplifier on
// (RL5) Sub 4 amplifier switch-on count
// (RL6) Sub 5 qualifier, zero by default
// (RL7) Init error qualifier: index high, sub low
// (RL8) Summary errors carry underlying error number
// (RL9) Last stop cause, read-only, resets zero
// (RL10) Write to clear command empties memory
// (RL11) Status bit 15 flags error or warning
// (RL12) Status bit 5 shows internal monitoring
// (RL13) Status bit 6 shows external monitoring
// (RL14) Status bit 7 shows controller warning
// (RL15) Report bad accesses back to master
// (RL16) When full, drop oldest, append newest
`ifndef EMLOG_MAP_SVH
`define EMLOG_MAP_SVH

`define EMLOG_N_ENTRIES  5'h14
`define EMLOG_IDX_FIRST  16'h0384
`define EMLOG_IDX_LAST   16'h0397
`define EMLOG_IDX_CMD    16'h0020
`define EMLOG_SUB_CLEAR  8'h02
`define EMLOG_SUB_STOP   8'h07
`define EMLOG_SUB_NUM    8'h01
`define EMLOG_SUB_CLASS  8'h02
`define EMLOG_SUB_TIME   8'h03
`define EMLOG_SUB_AMP    8'h04
`define EMLOG_SUB_QUAL   8'h05
`define EMLOG_BIT_INT    5
`define EMLOG_BIT_EXT    6
`define EMLOG_BIT_WARN   7
`define EMLOG_BIT_ERR    15
`define EMLOG_E_INIT     16'h1855
`define EMLOG_E_MANUAL   16'h181B
`define EMLOG_E_REFMOVE  16'h181F
`define EMLOG_E_EXTREF   16'h181D
`define EMLOG_E_NOPARAM  16'h1001
`define EMLOG_E_NOWRITE  16'h1008
`define EMLOG_E_NODATA   16'h1014
`define EMLOG_MS_NS      1000000
`define EMLOG_CLK_NS     25

`endif

// ---- verilog/emlog_pkg.sv ----
// Types shared by the error memory log modules
package emlog_pkg;

	typedef struct packed {
		logic [15:0] number;
		logic [15:0] err_class;
		logic [15:0] time_ms;
		logic [15:0] amp_cycles;
		logic [31:0] qualifier;
	} emlog_entry_s;

	typedef struct packed {
		logic        write;
		logic [15:0] index;
		logic [7:0]  subindex;
		logic [15:0] wdata;
	} emlog_req_s;

	typedef struct packed {
		logic        error;
		logic [31:0] data;
	} emlog_rsp_s;

	typedef enum logic [1:0] {
		EMLOG_KIND_ENTRY,
		EMLOG_KIND_STOP,
		EMLOG_KIND_CLEAR,
		EMLOG_KIND_FAULT
	} emlog_kind_e;

endpackage

// ---- verilog/emlog_mem.sv ----
// Entry storage with registered read data
`timescale 1ns/1ps
module emlog_mem
	import emlog_pkg::*;
#(
	parameter int DEPTH = 20,
	parameter int AW    = 5
) (
	// Clock
	input  wire logic         clk_i,
	// Write port
	input  wire logic         we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire emlog_entry_s wdata_i,
	// Read port
	input  wire logic [AW-1:0] raddr_i,
	output emlog_entry_s      rdata_o
);

	emlog_entry_s mem [DEPTH];
	emlog_entry_s rdata_reg;

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_reg <= mem[raddr_i];
	end

	assign rdata_o = rdata_reg;

endmodule

// ---- verilog/emlog_ts.sv ----
// Millisecond time since amplifier switch-on and switch-on counter
`timescale 1ns/1ps
module emlog_ts #(
	parameter int MS_CYCLES = 40000
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Amplifier state
	input  wire logic        amp_on_i,
	// Counters
	output logic      [15:0] time_ms_o,
	output logic      [15:0] amp_cycles_o
);

	logic [31:0] pre_reg,  pre_next;
	logic [15:0] ms_reg,   ms_next;
	logic [15:0] cyc_reg,  cyc_next;
	logic        amp_reg,  amp_next;

	always_comb begin
		amp_next = amp_on_i;
		pre_next = pre_reg;
		ms_next  = ms_reg;
		cyc_next = cyc_reg;
		// (RL5) count switch-on edges
		if (amp_on_i && !amp_reg) begin
			cyc_next = cyc_reg + 16'h0001;
		end
		// (RL4) ms restart at switch-on
		if (amp_on_i && !amp_reg) begin
			pre_next = 32'h0;
			ms_next  = 16'h0000;
		end else if (amp_on_i) begin
			if (pre_reg == 32'(MS_CYCLES - 1)) begin
				pre_next = 32'h0;
				ms_next  = ms_reg + 16'h0001;
			end else begin
				pre_next = pre_reg + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pre_reg <= 32'h0;
			ms_reg  <= 16'h0000;
			cyc_reg <= 16'h0000;
			amp_reg <= 1'b0;
		end else begin
			pre_reg <= pre_next;
			ms_reg  <= ms_next;
			cyc_reg <= cyc_next;
			amp_reg <= amp_next;
		end
	end

	assign time_ms_o    = ms_reg;
	assign amp_cycles_o = cyc_reg;

endmodule

// ---- verilog/emlog_top.sv ----
// Error memory, last stop cause and fieldbus status flags
`timescale 1ns/1ps
`include "emlog_map.svh"
module emlog_top
	import emlog_pkg::*;
#(
	parameter int MS_CYCLES = `EMLOG_MS_NS / `EMLOG_CLK_NS
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Parameter access from the fieldbus master
	input  wire logic        req_valid_i,
	input  wire emlog_req_s  req_i,
	output logic             rsp_valid_o,
	output emlog_rsp_s       rsp_o,
	// Fault reports from the monitoring logic
	input  wire logic        err_valid_i,
	input  wire logic [15:0] err_number_i,
	input  wire logic [15:0] err_class_i,
	input  wire logic        err_stop_i,
	input  wire logic [15:0] err_param_index_i,
	input  wire logic [15:0] err_param_sub_i,
	input  wire logic [15:0] err_detail_i,
	// Monitoring levels
	input  wire logic        amp_on_i,
	input  wire logic        internal_fault_flag_i,
	input  wire logic        external_monitor_flag_i,
	input  wire logic        warning_i,
	// Status
	output logic      [15:0] fieldbus_status_word_o,
	output logic      [15:0] last_stop_cause_o,
	output logic      [4:0]  entry_count_o
);

	localparam logic [4:0] NENT = `EMLOG_N_ENTRIES;

	// Ring position of the i-th oldest entry
	function automatic logic [4:0] emlog_wrap(input logic [4:0] a, input logic [4:0] b);
		logic [5:0] s;
		s = {1'b0, a} + {1'b0, b};
		if (s >= {1'b0, NENT}) begin
			s = s - {1'b0, NENT};
		end
		return s[4:0];
	endfunction

	// Entry index window, shared by decode and read address
	function automatic logic emlog_is_entry(input logic [15:0] idx);
		return (idx >= `EMLOG_IDX_FIRST) && (idx <= `EMLOG_IDX_LAST);
	endfunction

	// Index/sub-index decode; code is zero when access is legal
	function automatic logic [17:0] emlog_decode(input emlog_req_s r, input logic [4:0] count);
		logic [15:0]  code;
		emlog_kind_e  kind;
		logic [15:0]  slot;
		code = 16'h0000;
		kind = EMLOG_KIND_FAULT;
		slot = r.index - `EMLOG_IDX_FIRST;
		if (emlog_is_entry(r.index)) begin
			kind = EMLOG_KIND_ENTRY;
			// (RL3) entry fields read-only
			if (r.subindex < `EMLOG_SUB_NUM || r.subindex > `EMLOG_SUB_QUAL) begin
				code = `EMLOG_E_NOPARAM;
			end else if (r.write) begin
				code = `EMLOG_E_NOWRITE;
			end else if (slot[4:0] >= count) begin
				code = `EMLOG_E_NODATA;
			end
		end else if (r.index == `EMLOG_IDX_CMD && r.subindex == `EMLOG_SUB_STOP) begin
			kind = EMLOG_KIND_STOP;
			// (RL9) stop cause read-only
			if (r.write) begin
				code = `EMLOG_E_NOWRITE;
			end
		end else if (r.index == `EMLOG_IDX_CMD && r.subindex == `EMLOG_SUB_CLEAR) begin
			kind = EMLOG_KIND_CLEAR;
		end else begin
			code = `EMLOG_E_NOPARAM;
		end
		if (code != 16'h0000) begin
			kind = EMLOG_KIND_FAULT;
		end
		return {kind, code};
	endfunction

	// Ring and control state
	logic [4:0]   oldest_reg,  oldest_next;
	logic [4:0]   count_reg,   count_next;
	logic [15:0]  stop_reg,    stop_next;
	logic [15:0]  clear_reg,   clear_next;
	logic         err_reg,     err_next;
	// Response pipeline
	logic         s1_valid_reg, s1_valid_next;
	emlog_kind_e  s1_kind_reg,  s1_kind_next;
	logic [7:0]   s1_sub_reg,   s1_sub_next;
	logic [15:0]  s1_code_reg,  s1_code_next;
	logic         rsp_valid_reg, rsp_valid_next;
	emlog_rsp_s   rsp_reg,      rsp_next;

	logic [17:0]  dec;
	emlog_kind_e  dec_kind;
	logic [15:0]  dec_code;
	logic         do_clear;
	logic [4:0]   base_oldest;
	logic [4:0]   base_count;
	logic         mem_we;
	logic [4:0]   mem_waddr;
	logic [4:0]   mem_raddr;
	emlog_entry_s mem_wdata;
	emlog_entry_s mem_rdata;
	logic [15:0]  time_ms;
	logic [15:0]  amp_cycles;

	emlog_ts #(
		.MS_CYCLES (MS_CYCLES)
	) u_ts (
		.clk_i        (clk_i),
		.rst_n_i      (rst_n_i),
		.amp_on_i     (amp_on_i),
		.time_ms_o    (time_ms),
		.amp_cycles_o (amp_cycles)
	);

	// (RL1) separate store of twenty entries
	emlog_mem #(
		.DEPTH (int'(`EMLOG_N_ENTRIES)),
		.AW    (5)
	) u_mem (
		.clk_i   (clk_i),
		.we_i    (mem_we),
		.waddr_i (mem_waddr),
		.wdata_i (mem_wdata),
		.raddr_i (mem_raddr),
		.rdata_o (mem_rdata)
	);

	assign dec       = emlog_decode(req_i, count_reg);
	assign dec_kind  = emlog_kind_e'(dec[17:16]);
	assign dec_code  = dec[15:0];
	assign do_clear  = req_valid_i && req_i.write && (dec_kind == EMLOG_KIND_CLEAR);
	// (RL2) slot offset from the oldest entry; parked at zero outside the window
	assign mem_raddr = emlog_is_entry(req_i.index) ?
		emlog_wrap(oldest_reg, 5'(req_i.index - `EMLOG_IDX_FIRST)) : 5'h00;

	// New entry assembly
	always_comb begin
		mem_wdata.number     = err_number_i;
		mem_wdata.err_class  = err_class_i;
		// (RL4) timestamp since switch-on
		mem_wdata.time_ms    = time_ms;
		// (RL5) switch-on count at logging
		mem_wdata.amp_cycles = amp_cycles;
		// (RL6) qualifier zero by default
		mem_wdata.qualifier  = 32'h0000_0000;
		if (err_number_i == `EMLOG_E_INIT) begin
			// (RL7) index high, sub-index low
			mem_wdata.qualifier = {err_param_index_i, err_param_sub_i};
		end else if (err_number_i == `EMLOG_E_MANUAL || err_number_i == `EMLOG_E_REFMOVE ||
			     err_number_i == `EMLOG_E_EXTREF) begin
			// (RL8) underlying error number
			mem_wdata.qualifier = {16'h0000, err_detail_i};
		end
	end

	// Ring update; a clear in the same cycle as a fault keeps the fault
	always_comb begin
		base_oldest = oldest_reg;
		base_count  = count_reg;
		// (RL10) clear empties the memory
		if (do_clear) begin
			base_oldest = 5'h00;
			base_count  = 5'h00;
		end
		oldest_next = base_oldest;
		count_next  = base_count;
		mem_we      = err_valid_i;
		mem_waddr   = emlog_wrap(base_oldest, base_count);
		if (err_valid_i) begin
			if (base_count == NENT) begin
				// (RL16) overwrite oldest when full
				mem_waddr   = base_oldest;
				oldest_next = emlog_wrap(base_oldest, 5'h01);
			end else begin
				count_next = base_count + 5'h01;
			end
		end
	end

	// Stop cause, clear value and sticky error flag
	always_comb begin
		stop_next  = stop_reg;
		clear_next = clear_reg;
		err_next   = err_reg;
		// (RL10) keep written value, drop flag
		if (do_clear) begin
			clear_next = req_i.wdata;
			err_next   = 1'b0;
		end
		// (RL11) new fault wins over clear
		if (err_valid_i) begin
			err_next = 1'b1;
			// (RL9) record interruption cause
			if (err_stop_i) begin
				stop_next = err_number_i;
			end
		end
	end

	// Request pipeline: decode, then answer
	always_comb begin
		s1_valid_next  = req_valid_i;
		s1_kind_next   = dec_kind;
		s1_sub_next    = req_i.subindex;
		s1_code_next   = dec_code;
		rsp_valid_next = s1_valid_reg;
		// Answer stands until the next one
		rsp_next       = rsp_reg;
		if (s1_valid_reg) begin
			rsp_next.error = 1'b0;
			rsp_next.data  = 32'h0000_0000;
			case (s1_kind_reg)
				EMLOG_KIND_ENTRY: begin
					// (RL3-RL6) number, class, time, switch-on count and qualifier fields
					case (s1_sub_reg)
						`EMLOG_SUB_NUM:   rsp_next.data = {16'h0000, mem_rdata.number};
						`EMLOG_SUB_CLASS: rsp_next.data = {16'h0000, mem_rdata.err_class};
						`EMLOG_SUB_TIME:  rsp_next.data = {16'h0000, mem_rdata.time_ms};
						`EMLOG_SUB_AMP:   rsp_next.data = {16'h0000, mem_rdata.amp_cycles};
						default:          rsp_next.data = mem_rdata.qualifier;
					endcase
				end
				EMLOG_KIND_STOP: begin
					rsp_next.data = {16'h0000, stop_reg};
				end
				EMLOG_KIND_CLEAR: begin
					rsp_next.data = {16'h0000, clear_reg};
				end
				default: begin
					// (RL15) report access error code
					rsp_next.error = 1'b1;
					rsp_next.data  = {16'h0000, s1_code_reg};
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			oldest_reg <= 5'h00;
			count_reg  <= 5'h00;
		end else begin
			oldest_reg <= oldest_next;
			count_reg  <= count_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stop_reg  <= 16'h0000;
			clear_reg <= 16'h0000;
			err_reg   <= 1'b0;
		end else begin
			stop_reg  <= stop_next;
			clear_reg <= clear_next;
			err_reg   <= err_next;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s1_valid_reg  <= 1'b0;
			s1_kind_reg   <= EMLOG_KIND_FAULT;
			s1_sub_reg    <= 8'h00;
			s1_code_reg   <= 16'h0000;
			rsp_valid_reg <= 1'b0;
			rsp_reg       <= '0;
		end else begin
			s1_valid_reg  <= s1_valid_next;
			s1_kind_reg   <= s1_kind_next;
			s1_sub_reg    <= s1_sub_next;
			s1_code_reg   <= s1_code_next;
			rsp_valid_reg <= rsp_valid_next;
			rsp_reg       <= rsp_next;
		end
	end

	// Status word; other bits belong to other blocks and read zero here
	always_comb begin
		fieldbus_status_word_o = 16'h0000;
		// (RL12) internal monitoring state
		fieldbus_status_word_o[`EMLOG_BIT_INT]  = internal_fault_flag_i;
		// (RL13) external monitoring state
		fieldbus_status_word_o[`EMLOG_BIT_EXT]  = external_monitor_flag_i;
		// (RL14) controller warning
		fieldbus_status_word_o[`EMLOG_BIT_WARN] = warning_i;
		// (RL11) error or warning pending
		fieldbus_status_word_o[`EMLOG_BIT_ERR]  = err_reg | warning_i;
	end

	assign rsp_valid_o       = rsp_valid_reg;
	assign rsp_o             = rsp_reg;
	assign last_stop_cause_o = stop_reg;
	assign entry_count_o     = count_reg;

endmodule

// ---- verification/emlog_chk_assertions.sv ----
// Port assertions for the error memory log
`timescale 1ns/1ps
`include "emlog_map.svh"
module emlog_chk
	import emlog_pkg::*;
(
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	// Parameter port
	input wire logic        req_valid_i,
	input wire emlog_req_s  req_i,
	input wire logic        rsp_valid_o,
	// Fault port
	input wire logic        err_valid_i,
	input wire logic [15:0] err_number_i,
	input wire logic        err_stop_i,
	// Levels and status
	input wire logic        internal_fault_flag_i,
	input wire logic        external_monitor_flag_i,
	input wire logic        warning_i,
	input wire logic [15:0] fieldbus_status_word_o,
	input wire logic [15:0] last_stop_cause_o,
	input wire logic [4:0]  entry_count_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	wire logic [15:0] sw = fieldbus_status_word_o;
	wire logic        full = entry_count_o == `EMLOG_N_ENTRIES;
	wire logic        clr = req_valid_i && req_i.write && req_i.index == `EMLOG_IDX_CMD
		&& req_i.subindex == `EMLOG_SUB_CLEAR;

	rsp_lat_a: assert property (req_valid_i |-> ##2 rsp_valid_o)
		else $error("late answer");
	mon_bits_a: assert property (sw[6:5] == {external_monitor_flag_i, internal_fault_flag_i})
		else $error("monitor bits");
	warn_bit_a: assert property (sw[7] == warning_i && (sw[15] || !warning_i))
		else $error("warning bit");
	err_flag_a: assert property (err_valid_i |=> sw[15])
		else $error("error flag");
	cnt_step_a: assert property (err_valid_i && !clr && !full
		|=> entry_count_o == $past(entry_count_o) + 5'h01) else $error("count step");
	cnt_full_a: assert property (err_valid_i && !clr && full |=> full)
		else $error("full count");
	cnt_clear_a: assert property (clr |=> entry_count_o == 5'($past(err_valid_i)))
		else $error("clear count");
	stop_upd_a: assert property (err_valid_i && err_stop_i
		|=> last_stop_cause_o == $past(err_number_i)) else $error("stop cause");
	full_c: cover property (full && err_valid_i);
	clear_c: cover property (clr);
	stop_c: cover property (err_valid_i && err_stop_i);
endmodule

bind emlog_top emlog_chk i_chk (.*);

// ---- verification/emlog_master.sv ----
// Fieldbus master model issuing parameter requests
`timescale 1ns/1ps
module emlog_master
	import emlog_pkg::*;
(
	// Clock
	input  wire logic       clk_i,
	// Answers
	input  wire logic       rsp_valid_i,
	input  wire emlog_rsp_s rsp_i,
	// Requests
	output logic            req_valid_o,
	output emlog_req_s      req_o
);
	initial begin
		req_valid_o = 1'h0;
		req_o = '0;
	end

	task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
		input logic [15:0] wd, output emlog_rsp_s r);
		int n;
		n = 0;
		req_valid_o <= 1'h1;
		req_o <= '{w, idx, sub, wd};
		@(posedge clk_i);
		req_valid_o <= 1'h0;
		// Scrambled so a stale request never looks valid
		req_o <= ~req_o;
		do begin
			@(posedge clk_i);
			n++;
		end while (!rsp_valid_i && n < 8);
		r = rsp_i;
	endtask
endmodule

// ---- verification/emlog_top_bench.sv ----
// Self-checking bench for the error memory log
`timescale 1ns/1ps
module emlog_top_bench
	import emlog_pkg::*;
;
	logic        clk_i = 1'h0;
	logic        rst_n_i = 1'h0;
	logic        req_valid_i;
	emlog_req_s  req_i;
	logic        rsp_valid_o;
	emlog_rsp_s  rsp_o;
	logic        err_valid_i = 1'h0;
	logic [15:0] err_number_i = 16'h0000;
	logic [15:0] err_class_i = 16'h0000;
	logic        err_stop_i = 1'h0;
	logic [15:0] err_param_index_i = 16'h0029;
	logic [15:0] err_param_sub_i = 16'h0023;
	logic [15:0] err_detail_i = 16'h1846;
	logic        amp_on_i = 1'h0;
	logic        internal_fault_flag_i = 1'h0;
	logic        external_monitor_flag_i = 1'h0;
	logic        warning_i = 1'h0;
	logic [15:0] fieldbus_status_word_o;
	logic [15:0] last_stop_cause_o;
	logic [4:0]  entry_count_o;
	int          errors = 0;
	int          cmp_count = 0;
	emlog_rsp_s  r;

	always #12.5 clk_i = ~clk_i;

	emlog_top #(.MS_CYCLES(4)) i_dut (.*);
	emlog_master i_mst (.clk_i(clk_i), .rsp_valid_i(rsp_valid_o), .rsp_i(rsp_o),
		.req_valid_o(req_valid_i), .req_o(req_i));

	task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [32:0] exp);
		i_mst.access(1'h0, idx, sub, 16'h0000, r);
		chk(r, exp);
	endtask

	task automatic log_err(input logic [15:0] num, input logic [15:0] cls, input logic stp);
		err_valid_i <= 1'h1;
		err_number_i <= num;
		err_class_i <= cls;
		err_stop_i <= stp;
		@(posedge clk_i);
		err_valid_i <= 1'h0;
		@(posedge clk_i);
	endtask

	task automatic t_flags;
		chk(33'(last_stop_cause_o), 33'h0);
		rd(16'h0020, 8'h07, 33'h0);
		rd(16'h0384, 8'h01, 33'h1_0000_1014);
		for (int k = 0; k < 3; k++) begin
			{warning_i, external_monitor_flag_i, internal_fault_flag_i} <= 3'h1 << k;
			@(posedge clk_i);
			chk(33'(fieldbus_status_word_o), 33'({k == 2, 7'h00, k == 2, k == 1, k == 0, 5'h00}));
		end
		{warning_i, external_monitor_flag_i, internal_fault_flag_i} <= 3'h0;
		@(posedge clk_i);
		chk(33'(fieldbus_status_word_o), 33'h0);
		$display("flag test done");
	endtask

	task automatic t_log;
		logic [15:0] code [5];
		logic [31:0] q;
		code = '{16'h1855, 16'h181B, 16'h181F, 16'h181D, 16'h1234};
		amp_on_i <= 1'h1;
		@(posedge clk_i);
		amp_on_i <= 1'h0;
		@(posedge clk_i);
		amp_on_i <= 1'h1;
		repeat (40) @(posedge clk_i);
		for (int i = 0; i < 5; i++)
			log_err(code[i], 16'(i), i == 4);
		i_mst.access(1'h0, 16'h0384, 8'h03, 16'h0000, r);
		// One ms of slack for the timer phase
		chk(33'(r.data > 32'h8 && r.data < 32'hC), 33'h1);
		rd(16'h0384, 8'h04, 33'h2);
		for (int i = 0; i < 5; i++) begin
			q = i == 0 ? 32'h0029_0023 : i < 4 ? 32'h1846 : 32'h0;
			rd(16'h0384 + 16'(i), 8'h01, 33'(code[i]));
			rd(16'h0384 + 16'(i), 8'h02, 33'(i));
			rd(16'h0384 + 16'(i), 8'h05, 33'(q));
		end
		chk(33'(last_stop_cause_o), 33'h1234);
		chk(33'(fieldbus_status_word_o), 33'h8000);
		rd(16'h0389, 8'h01, 33'h1_0000_1014);
		rd(16'h0384, 8'h06, 33'h1_0000_1001);
		i_mst.access(1'h1, 16'h0020, 8'h07, 16'h0001, r);
		chk(r, 33'h1_0000_1008);
		i_mst.access(1'h1, 16'h0384, 8'h01, 16'h0001, r);
		chk(33'(r.error), 33'h1);
		$display("log test done");
	endtask

	task automatic t_full;
		for (int k = 0; k < 20; k++)
			log_err(16'h2000 + 16'(k), 16'h0001, 1'h0);
		chk(33'(entry_count_o), 33'h14);
		rd(16'h0384, 8'h01, 33'h2000);
		rd(16'h0397, 8'h01, 33'h2013);
		$display("full test done");
	endtask

	task automatic t_clear;
		i_mst.access(1'h1, 16'h0020, 8'h02, 16'h5A5A, r);
		// Write answer carries the value now stored
		chk(r, 33'h0_0000_5A5A);
		chk(33'(entry_count_o), 33'h0);
		chk(33'(fieldbus_status_word_o), 33'h0);
		rd(16'h0020, 8'h02, 33'h5A5A);
		rd(16'h0384, 8'h01, 33'h1_0000_1014);
		$display("clear test done");
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'h1;
		@(posedge clk_i);
		t_flags();
		t_log();
		t_full();
		t_clear();
		report_and_stop();
	end

	initial begin
		repeat (3000) @(posedge clk_i);
		errors++;
		report_and_stop();
	end
endmodule
